// ===== rps_regs.svh
// Functional notes
// - At power-up, see an in-window input supply sample before any step.
// - Turn on input current limiter before any regulator enable.
// - Enable core regulator first, then wait for its power-good.
// - Next regulator only after previous power-good; repeat for every rail in order.
// - Check input supply against undervoltage and overvoltage limits continuously; code trips on it only from the limiter step through run.
// - Supply out of regulation abandons normal operation and starts power-down.
// - Per rail on shutdown: drop enable, then wait for power-good to fall.
// - After power-good falls, switch on that rail's drain transistor.
// - Then disable the next rail and repeat until all rails are off.
// - Each rail drains within 10 ms; full shutdown under 100 ms.
// - Rails are arranged as three ordered power groups both ways.
// - Four enables and power-goods; drain outputs on rails one, two, four only.
// - Only the scaled input supply channel drives sequencing decisions.
// - Optionally drain residual rail voltage before enabling its regulator.
// - Optionally let core and transceiver rails decay without drain transistors.
// - Logic runs from one system clock from a frequency synthesizer.
// - Synchronous reset, released only after the synthesizer reports lock.
`ifndef RPS_REGS_SVH
`define RPS_REGS_SVH
`define RPS_NRAILS      4
`define RPS_DRAIN_MASK  4'hb
`define RPS_GROUP_MAP   8'ha4
`define RPS_CLK_KHZ     250000
`define RPS_TIMEOUT_MS  10
`define RPS_TIMEOUT_CYC (`RPS_TIMEOUT_MS * `RPS_CLK_KHZ)
`define RPS_DRAIN_MS    10
`define RPS_DRAIN_CYC   (`RPS_DRAIN_MS * `RPS_CLK_KHZ)
`define RPS_UV_CODE     12'h900
`define RPS_OV_CODE     12'hc00
`define RPS_TMR_W       22
`endif

// ===== rps_pkg.sv
package rps_pkg;
  typedef enum logic [7:0] {
    S_CHECK  = 8'h01,
    S_LIMIT  = 8'h02,
    S_PREB   = 8'h04,
    S_ENABLE = 8'h08,
    S_RUN    = 8'h10,
    S_DIS    = 8'h20,
    S_DRAIN  = 8'h40,
    S_OFF    = 8'h80
  } rps_state_t;
endpackage

// ===== rps_seq.sv
`timescale 1ns/10ps
`include "rps_regs.svh"
module rps_seq import rps_pkg::*; #(
  parameter int         TIMEOUT_CYC = `RPS_TIMEOUT_CYC,
  parameter int         DRAIN_CYC   = `RPS_DRAIN_CYC,
  parameter logic [11:0] UV_CODE    = `RPS_UV_CODE,
  parameter logic [11:0] OV_CODE    = `RPS_OV_CODE
) (
  input  wire  logic        clk,
  input  wire  logic        sys_rst,
  input  wire  logic [11:0] supply_code,
  input  wire  logic        supply_valid,
  input  wire  logic [3:0]  rail_good_in,
  input  wire  logic [3:0]  rail_resid_in,
  input  wire  logic        opt_prebias,
  input  wire  logic        opt_soft_decay,
  output logic       [3:0]  rail_en,
  output logic       [3:0]  rail_drain_drive,
  output logic              limiter_en,
  output logic       [1:0]  power_group,
  output logic              seq_done,
  output logic              fault
);

  localparam int TW = `RPS_TMR_W;

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  // Supply code inside the regulation window
  function automatic logic in_win(input logic [11:0] c);
    in_win = (c >= UV_CODE) && (c <= OV_CODE);
  endfunction

  // Group of a rail: core, transceiver, then the rest
  function automatic logic [1:0] grp_of(input logic [1:0] i);
    logic [7:0] m;
    m = `RPS_GROUP_MAP;
    grp_of = m[{i, 1'b0} +: 2];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only stage two is read by logic
  logic [3:0] good_m_q, good_s_q, resid_m_q, resid_s_q;
  always_ff @(posedge clk) begin
    good_m_q  <= rail_good_in;
    good_s_q  <= good_m_q;
    resid_m_q <= rail_resid_in;
    resid_s_q <= resid_m_q;
  end

  ////////////////////////////////////////////////////////////////////////
  // State and decode
  rps_state_t      state_q, state_d;
  logic [1:0]      idx_q, idx_d;
  logic [TW-1:0]   tmr_q;
  logic [3:0]      en_q, en_d, drn_q, drn_d;
  logic            lim_q, lim_d, flt_q, flt_d, done_q;
  logic [1:0]      grp_q;

  // Only the input supply channel feeds decisions
  wire sample_ok  = supply_valid && in_win(supply_code);
  wire sample_bad = supply_valid && !in_win(supply_code);
  wire good_cur   = good_s_q[idx_q];
  wire last_rail  = (idx_q == 2'(`RPS_NRAILS - 1));
  wire tmo_hit    = (tmr_q == TW'(TIMEOUT_CYC - 1));
  wire drn_hit    = (tmr_q == TW'(DRAIN_CYC - 1));
  wire [3:0] dmask = `RPS_DRAIN_MASK;
  // Soft decay spares the two heavy rails' transistors
  wire drn_allow  = dmask[idx_q] && !(opt_soft_decay && grp_of(idx_q) != 2'h2);
  wire preb_need  = opt_prebias && dmask[idx_q] && resid_s_q[idx_q];
  wire up_phase   = (state_q == S_LIMIT) || (state_q == S_PREB) ||
                    (state_q == S_ENABLE) || (state_q == S_RUN);

  // Next state; power-down walks idx downwards, the reverse of power-up
  always_comb begin
    state_d = state_q;
    idx_d   = idx_q;
    en_d    = en_q;
    drn_d   = drn_q;
    lim_d   = lim_q;
    flt_d   = flt_q;
    case (state_q)
      S_CHECK: begin
        if (sample_ok) begin
          state_d = S_LIMIT;
        end
      end
      S_LIMIT: begin
        lim_d   = 1'b1;
        state_d = S_PREB;
      end
      S_PREB: begin
        drn_d[idx_q] = preb_need;
        if (!preb_need) begin
          state_d = S_ENABLE;
          en_d[idx_q] = 1'b1;
        end else if (tmo_hit) begin
          flt_d   = 1'b1;
          drn_d   = 4'h0;
          state_d = S_DIS;
        end
      end
      S_ENABLE: begin
        if (good_cur) begin
          state_d = last_rail ? S_RUN : S_PREB;
          idx_d   = last_rail ? idx_q : idx_q + 2'h1;
        end else if (tmo_hit) begin
          flt_d   = 1'b1;
          en_d[idx_q] = 1'b0;
          state_d = S_DIS;
        end
      end
      S_RUN: begin
        if (!(&good_s_q)) begin // Lost power-good counts as a fault
          flt_d = 1'b1;
          en_d[idx_q] = 1'b0;
          state_d = S_DIS;
        end
      end
      S_DIS: begin
        if (!good_cur || tmo_hit) begin
          flt_d   = flt_q | tmo_hit;
          drn_d[idx_q] = drn_allow;
          state_d = S_DRAIN;
        end
      end
      S_DRAIN: begin
        if (drn_hit) begin
          if (idx_q == 2'h0) begin
            state_d = S_OFF;
            lim_d   = 1'b0;
          end else begin
            idx_d   = idx_q - 2'h1;
            en_d[idx_q - 2'h1] = 1'b0;
            state_d = S_DIS;
          end
        end
      end
      S_OFF: begin
        state_d = S_OFF; // Held off until the next reset
      end
      default: begin
        state_d = S_CHECK;
      end
    endcase
    // Supply trip overrides any power-up step
    if (up_phase && sample_bad) begin
      state_d = S_DIS;
      idx_d   = idx_q;
      en_d    = en_q & ~(4'h1 << idx_q);
      drn_d   = 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers; reset is synchronous, released by the lock-gated reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= S_CHECK;
      idx_q   <= 2'h0;
      en_q    <= 4'h0;
      drn_q   <= 4'h0;
      lim_q   <= 1'b0;
      flt_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      idx_q   <= idx_d;
      en_q    <= en_d;
      drn_q   <= drn_d & dmask;
      lim_q   <= lim_d;
      flt_q   <= flt_d;
    end
  end

  // Wait timer restarts on every state or rail change
  always_ff @(posedge clk) begin
    if (sys_rst || state_d != state_q || idx_d != idx_q) begin
      tmr_q <= '0;
    end else if (!tmo_hit || !drn_hit) begin
      tmr_q <= tmr_q + TW'(1);
    end
  end

  // Status flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      done_q <= 1'b0;
      grp_q  <= 2'h0;
    end else begin
      done_q <= (state_d == S_RUN);
      grp_q  <= grp_of(idx_d);
    end
  end

  assign rail_en          = en_q;
  assign rail_drain_drive = drn_q;
  assign limiter_en       = lim_q;
  assign power_group      = grp_q;
  assign seq_done         = done_q;
  assign fault            = flt_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  check_first_a: assert property ((state_q == S_CHECK) |-> (en_q == 4'h0 && !lim_q))
    else $error("rails or limiter on before supply check");
  limiter_first_a: assert property ((en_q != 4'h0) |-> lim_q)
    else $error("regulator enabled without current limiter");
  en_chain_a: assert property ((en_q[1] |-> en_q[0]) and (en_q[2] |-> en_q[1]) and (en_q[3] |-> en_q[2]))
    else $error("enable order broken");
  wait_good_a: assert property ($rose(en_q[1]) |-> $past(good_s_q[0]))
    else $error("second rail enabled before first power-good");
  supply_trip_a: assert property ((state_q == S_RUN && sample_bad) |=> (state_q == S_DIS && !en_q[3]))
    else $error("supply trip did not start power-down");
  drain_off_a: assert property ((state_q == S_DIS) ##1 (state_q == S_DRAIN) |->
                                (!en_q[idx_q] && $past(!good_cur || tmo_hit)))
    else $error("drain with regulator still enabled");
  no_drain3_a: assert property (!drn_q[2])
    else $error("drain driven on rail three");
  soft_decay_a: assert property ((opt_soft_decay && state_q == S_DRAIN && idx_q < 2'h2) |-> !drn_q[idx_q])
    else $error("soft decay rail drained");
  tmo_fault_a: assert property ((state_q == S_ENABLE && tmo_hit && !good_cur && !sample_bad) |=> (flt_q && state_q == S_DIS))
    else $error("timeout did not fault");

  run_c:   cover property (state_q == S_RUN);
  off_c:   cover property ((state_q == S_DRAIN) ##1 (state_q == S_OFF));
  fault_c: cover property ($rose(flt_q));
  preb_c:  cover property (state_q == S_PREB && drn_q != 4'h0);

endmodule // rps_seq

// ===== rps_rail_model.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////
module rps_rail_model #(
  parameter int DLY = 5
) (
  input  wire logic       clk,
  input  wire logic       hang,
  input  wire logic [3:0] rail_en,
  output logic      [3:0] rail_good_in
);
  int cnt [4];
  initial rail_good_in = 4'h0;
  // Good follows enable after a soft start; hang holds rail 2 low, even once it is up
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if ((rail_en[i] && !(hang && i == 2)) != rail_good_in[i]) begin
        if (cnt[i] == DLY) begin
          rail_good_in[i] <= ~rail_good_in[i];
          cnt[i]          <= 0;
        end else begin
          cnt[i] <= cnt[i] + 1;
        end
      end else begin
        cnt[i] <= 0;
      end
    end
  end
endmodule // rps_rail_model

// ===== rps_seq_tb.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////
module rps_seq_tb;
  logic        clk = 0, sys_rst = 1, supply_valid = 0, opt_prebias = 0, opt_soft_decay = 0, hang = 0;
  logic [11:0] supply_code = 12'h000;
  logic [3:0]  rail_good_in, rail_en, rail_drain_drive;
  logic [3:0]  rail_resid_in = 4'h0;
  logic [1:0]  power_group;
  logic        limiter_en, seq_done, fault;
  int          miscompares = 0, n_tests = 0, cycles = 0;
  localparam int DRAIN_T = 20;

  always #2 clk = ~clk;
  // Short counts keep the run brief
  rps_seq #(.TIMEOUT_CYC(50), .DRAIN_CYC(DRAIN_T)) rps_seq_i (.clk(clk), .sys_rst(sys_rst),
    .supply_code(supply_code), .supply_valid(supply_valid), .rail_good_in(rail_good_in),
    .rail_resid_in(rail_resid_in), .opt_prebias(opt_prebias), .opt_soft_decay(opt_soft_decay),
    .rail_en(rail_en), .rail_drain_drive(rail_drain_drive), .limiter_en(limiter_en),
    .power_group(power_group), .seq_done(seq_done), .fault(fault));
  rps_rail_model rps_rail_model_i (.clk(clk), .hang(hang), .rail_en(rail_en), .rail_good_in(rail_good_in));

  task chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      print_verdict;
    end
  end
  task sample(input logic [11:0] v);
    @(negedge clk);
    supply_code  = v;
    supply_valid = 1;
    @(negedge clk);
    supply_valid = 0;
  endtask
  task wait_out(input logic [7:0] v);
    int n;
    for (n = 0; n < 300 && {rail_en, rail_drain_drive} !== v; n++) @(negedge clk);
    chk({rail_en, rail_drain_drive}, v, "rail outputs");
  endtask
  task do_reset;
    sys_rst = 1;
    repeat (6) @(negedge clk);
    sys_rst = 0;
    @(negedge clk);
    chk({rail_en, rail_drain_drive}, 8'h00, "reset rails");
    chk({limiter_en, seq_done, fault, power_group}, 8'h00, "reset flags");
  endtask
  task t_power_up;
    sample(12'h8ff);
    repeat (4) @(negedge clk);
    chk(limiter_en, 1'b0, "limiter on bad supply");
    sample(12'hc00);
    chk({limiter_en, rail_en}, 8'h00, "limiter early");
    @(negedge clk);
    chk({limiter_en, rail_en}, 8'h10, "limiter late");
    for (int i = 0; i < 4; i++) begin
      wait_out({(4'h2 << i) - 4'h1, 4'h0});
      chk(rail_good_in & (rail_en >> 1), rail_en >> 1, "enable before good");
      chk(power_group, (i > 1) ? 2'd2 : 2'(i), "group");
    end
    for (int n = 0; n < 100 && seq_done !== 1'b1; n++) @(negedge clk);
    chk(seq_done, 1'b1, "run not reached");
    $display("power up done");
  endtask
  task t_power_down;
    int dn;
    sample(12'h900);
    repeat (3) @(negedge clk);
    chk(seq_done, 1'b1, "window edge");
    sample(12'hc01);
    @(negedge clk);
    chk(rail_en, 4'h7, "last rail first");
    wait_out(8'h78);
    chk(rail_good_in[3], 1'b0, "drain before good fell");
    // Drain time is counted from the drain turning on to the next enable dropping
    for (dn = 0; dn < 300 && rail_en !== 4'h3; dn++) @(negedge clk);
    chk(8'(dn), 8'(DRAIN_T), "drain time");
    wait_out(8'h38);
    wait_out(8'h1a);
    wait_out(8'h0b);
    for (int n = 0; n < 100 && limiter_en !== 1'b0; n++) @(negedge clk);
    sample(12'ha00);
    repeat (4) @(negedge clk);
    chk({limiter_en, rail_en, rail_drain_drive[2]}, 6'h00, "off state");
    $display("power down done");
  endtask
  // Power-good lost while running: fault, then full reverse shutdown
  task t_good_loss;
    hang = 0;
    do_reset;
    sample(12'ha00);
    wait_out(8'hf0);
    for (int n = 0; n < 100 && seq_done !== 1'b1; n++) @(negedge clk);
    hang = 1;
    wait_out(8'h70);
    chk({fault, seq_done}, 2'b10, "good loss fault");
    wait_out(8'h0b);
    chk(fault, 1'b1, "fault sticky");
    $display("good loss done");
  endtask
  task t_timeout;
    opt_prebias    = 1;
    opt_soft_decay = 1;
    hang           = 1;
    rail_resid_in  = 4'h1;
    do_reset;
    sample(12'ha00);
    // Residual on rail 0 holds its enable off while drained
    wait_out(8'h01);
    rail_resid_in = 4'h0;
    wait_out(8'h10);
    wait_out(8'h70);
    wait_out(8'h30);
    chk(fault, 1'b1, "timeout fault");
    wait_out(8'h00);
    repeat (80) @(negedge clk);
    chk({fault, rail_drain_drive}, 8'h10, "soft decay");
    $display("timeout done");
  endtask
  initial begin
    do_reset;
    t_power_up;
    t_power_down;
    t_good_loss;
    t_timeout;
    print_verdict;
  end
endmodule // rps_seq_tb
